// file: rhpm_defs.svh
`ifndef RHPM_DEFS_SVH
`define RHPM_DEFS_SVH
`define RHPM_CMD_MASKS_RD   8'h13
`define RHPM_CMD_MASKS_WR   8'h93
`define RHPM_CMD_STATUS_RD  8'h14
`define RHPM_CMD_STATUS_WR  8'h94
`define RHPM_PPM_HI         18
`define RHPM_PPM_LO         16
`define RHPM_DFM_HI         2
`define RHPM_DFM_LO         0
`define RHPM_PPM_RST        3'h0
`define RHPM_DFM_RST        3'h0
`define RHPM_STAT_CHG_LO    16
`endif

// file: rhpm_pkg.sv
package rhpm_pkg;
  typedef enum logic [1:0] {
    RHPM_PWR_NONE,
    RHPM_PWR_ON,
    RHPM_PWR_OFF
  } rhpm_pwr_op_t;
  typedef enum {
    RHPM_IDLE,
    RHPM_ANSWER
  } rhpm_state_t;
endpackage : rhpm_pkg

// file: rhpm_port_power.sv
`include "rhpm_defs.svh"
module rhpm_port_power
  import rhpm_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         mask_bit,
  input  wire logic         per_port_switch_select,
  input  wire rhpm_pwr_op_t global_op,
  input  wire rhpm_pwr_op_t port_op,
  output logic              power_reg
);
  logic use_port;
  assign use_port = per_port_switch_select && mask_bit;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      power_reg <= 1'b0;
    else if (use_port)
    begin
      if (port_op == RHPM_PWR_ON)
        power_reg <= 1'b1;
      else if (port_op == RHPM_PWR_OFF)
        power_reg <= 1'b0;
    end
    else
    begin
      if (global_op == RHPM_PWR_ON)
        power_reg <= 1'b1;
      else if (global_op == RHPM_PWR_OFF)
        power_reg <= 1'b0;
    end
  end
endmodule : rhpm_port_power

// file: rhpm_root_hub.sv
// How it works
// - Bits 18 to 16 hold a port power mask choosing per-port or global control per port.
// - With switch select 1, a port with its mask bit set follows only per-port power on and off commands.
// - A port with its mask bit clear follows only the global power on and off commands.
// - With the switch select at 0 the mask is ignored and all ports follow global commands.
// - Mask bit 0 is reserved, bit 1 is port one and bit 2 is port two.
// - Bits 2 to 0 hold the device-fixed mask, a set bit meaning non-removable.
// - Fixed-mask bit 0 is reserved, bit 1 is port one and bit 2 is port two.
// - The status word has status flags in the low half and change flags in the high half.
// - Status word is read with code 14h and written with code 94h.
// - Port mask register is read with code 13h and written with code 93h.
// - Switch select 0 powers all ports together, 1 allows per-port power.
// - Both masks reset to board-chosen values set by the PPM_RESET and DFM_RESET parameters, with bit 0 cleared.
`include "rhpm_defs.svh"
module rhpm_root_hub
  import rhpm_pkg::*;
#(
  parameter int         NUM_PORTS = 2,
  parameter logic [2:0] PPM_RESET = `RHPM_PPM_RST,
  parameter logic [2:0] DFM_RESET = `RHPM_DFM_RST
)
(
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         cmd_valid,
  input  wire logic [7:0]   cmd_code,
  input  wire logic [31:0]  cmd_wdata,
  input  wire logic         per_port_switch_select,
  input  wire rhpm_pwr_op_t global_op,
  input  wire logic [2:0]   port_op_on,
  input  wire logic [2:0]   port_op_off,
  input  wire logic [15:0]  hub_status_in,
  input  wire logic [15:0]  hub_change_in,
  output logic [31:0]       rd_data_reg,
  output logic              rd_valid_reg,
  output logic [2:0]        port_power_reg,
  output logic [2:0]        device_fixed_mask_reg,
  output logic [31:0]       status_wr_data_reg,
  output logic              status_wr_reg
);
  logic [2:0]  port_power_mask_reg;
  logic [2:0]  power_int;
  logic [31:0] masks_word;
  logic [31:0] status_word;
  rhpm_state_t state_reg;

  function automatic rhpm_pwr_op_t port_cmd(input logic on, input logic off);
    if (on)
      return RHPM_PWR_ON;
    else if (off)
      return RHPM_PWR_OFF;
    else
      return RHPM_PWR_NONE;
  endfunction : port_cmd

  // mask writes, reserved bit 0 kept zero
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      port_power_mask_reg   <= PPM_RESET & 3'h6;
      device_fixed_mask_reg <= DFM_RESET & 3'h6;
    end
    else if (cmd_valid && cmd_code == `RHPM_CMD_MASKS_WR)
    begin
      port_power_mask_reg   <= cmd_wdata[`RHPM_PPM_HI:`RHPM_PPM_LO] & 3'h6;
      device_fixed_mask_reg <= cmd_wdata[`RHPM_DFM_HI:`RHPM_DFM_LO] & 3'h6;
    end
  end

  // read image with reserved bits zero
  always_comb
  begin
    masks_word = 32'h0;
    masks_word[`RHPM_PPM_HI:`RHPM_PPM_LO] = port_power_mask_reg;
    masks_word[`RHPM_DFM_HI:`RHPM_DFM_LO] = device_fixed_mask_reg;
  end

  assign status_word = {hub_change_in, hub_status_in};

  assign power_int[0] = 1'b0;
  generate
    for (genvar i = 1; i <= NUM_PORTS; i++)
    begin : g_port
      rhpm_port_power u_pp (
        .core_clk              (core_clk),
        .sys_rst               (sys_rst),
        .mask_bit              (port_power_mask_reg[i]),
        .per_port_switch_select(per_port_switch_select),
        .global_op             (global_op),
        .port_op               (port_cmd(port_op_on[i], port_op_off[i])),
        .power_reg             (power_int[i])
      );
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      port_power_reg <= 3'h0;
    else
      port_power_reg <= power_int;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rd_data_reg  <= 32'h0;
      rd_valid_reg <= 1'b0;
      state_reg    <= RHPM_IDLE;
    end
    else
    begin
      rd_valid_reg <= 1'b0;
      state_reg    <= RHPM_IDLE;
      case (state_reg)
        RHPM_IDLE, RHPM_ANSWER:
        begin
          if (cmd_valid && cmd_code == `RHPM_CMD_MASKS_RD)
          begin
            rd_data_reg  <= masks_word;
            rd_valid_reg <= 1'b1;
            state_reg    <= RHPM_ANSWER;
          end
          else if (cmd_valid && cmd_code == `RHPM_CMD_STATUS_RD)
          begin
            rd_data_reg  <= status_word;
            rd_valid_reg <= 1'b1;
            state_reg    <= RHPM_ANSWER;
          end
        end
        default:
          state_reg <= RHPM_IDLE;
      endcase
    end
  end

  // status write forwarded, reserved bits relied zero
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      status_wr_reg      <= 1'b0;
      status_wr_data_reg <= 32'h0;
    end
    else
    begin
      status_wr_reg <= cmd_valid && cmd_code == `RHPM_CMD_STATUS_WR;
      if (cmd_valid && cmd_code == `RHPM_CMD_STATUS_WR)
        status_wr_data_reg <= cmd_wdata;
    end
  end

  a_masks_reserved: assert property (@(posedge core_clk) disable iff (sys_rst)
    rd_valid_reg && $past(cmd_code) == `RHPM_CMD_MASKS_RD |-> (rd_data_reg & 32'hFFF8FFF8) == 32'h0)
    else $error("reserved mask bits not zero");
  a_masks_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmd_valid && cmd_code == `RHPM_CMD_MASKS_WR
    |=> port_power_mask_reg == ($past(cmd_wdata[18:16]) & 3'h6))
    else $error("mask write lost");
  a_fixed_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmd_valid && cmd_code == `RHPM_CMD_MASKS_WR
    |=> device_fixed_mask_reg == ($past(cmd_wdata[2:0]) & 3'h6))
    else $error("fixed mask write lost");
  a_masks_image: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmd_valid && cmd_code == `RHPM_CMD_MASKS_RD |=> rd_valid_reg
    && rd_data_reg[18:16] == $past(port_power_mask_reg)
    && rd_data_reg[2:0] == $past(device_fixed_mask_reg))
    else $error("mask read image wrong");
  a_mask_bit0: assert property (@(posedge core_clk) disable iff (sys_rst)
    !port_power_mask_reg[0] && !device_fixed_mask_reg[0])
    else $error("reserved bit 0 set");
  a_status_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmd_valid && cmd_code == `RHPM_CMD_STATUS_RD |=> rd_valid_reg && rd_data_reg == $past(status_word))
    else $error("status read wrong");
  a_status_half: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmd_valid && cmd_code == `RHPM_CMD_STATUS_RD
    |=> rd_data_reg[31:`RHPM_STAT_CHG_LO] == $past(hub_change_in)
    && rd_data_reg[15:0] == $past(hub_status_in))
    else $error("change half misplaced");
  a_no_stray_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(cmd_valid && (cmd_code == `RHPM_CMD_MASKS_RD || cmd_code == `RHPM_CMD_STATUS_RD))
    |=> !rd_valid_reg && $stable(rd_data_reg))
    else $error("read answer without read");
  a_status_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmd_valid && cmd_code == `RHPM_CMD_STATUS_WR
    |=> status_wr_reg && status_wr_data_reg == $past(cmd_wdata)
    ##1 !status_wr_reg || $past(cmd_valid))
    else $error("status write pulse wrong");
  a_no_stray_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(cmd_valid && cmd_code == `RHPM_CMD_STATUS_WR)
    |=> !status_wr_reg && $stable(status_wr_data_reg))
    else $error("status write without command");
  a_global_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
    !per_port_switch_select && global_op == RHPM_PWR_ON |=> power_int[1] && power_int[2])
    else $error("global on ignored");
  a_global_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    !per_port_switch_select && global_op == RHPM_PWR_OFF |=> !power_int[1] && !power_int[2])
    else $error("global off ignored");
  a_masked_port: assert property (@(posedge core_clk) disable iff (sys_rst)
    per_port_switch_select && port_power_mask_reg[1] && !port_op_on[1] && !port_op_off[1]
    |=> power_int[1] == $past(power_int[1]))
    else $error("masked port moved");
  a_port_on: assert property (@(posedge core_clk) disable iff (sys_rst)
    per_port_switch_select && port_power_mask_reg[1] && port_op_on[1] |=> power_int[1])
    else $error("port on ignored");
  a_unmasked_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    !port_power_mask_reg[2] && global_op == RHPM_PWR_OFF |=> !power_int[2] ##1 !port_power_reg[2])
    else $error("global off missed");
endmodule : rhpm_root_hub

// file: testbench.sv
`include "rhpm_defs.svh"
module testbench
  import rhpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic         core_clk               = 1'b0;
  logic         sys_rst                = 1'b1;
  logic         cmd_valid              = 1'b0;
  logic [7:0]   cmd_code               = 8'h00;
  logic [31:0]  cmd_wdata              = 32'h0;
  logic         per_port_switch_select = 1'b0;
  rhpm_pwr_op_t global_op              = RHPM_PWR_NONE;
  logic [2:0]   port_op_on             = 3'h0;
  logic [2:0]   port_op_off            = 3'h0;
  logic [15:0]  hub_status_in          = 16'h0;
  logic [15:0]  hub_change_in          = 16'h0;
  logic [31:0]  rd_data_reg;
  logic [31:0]  status_wr_data_reg;
  logic         rd_valid_reg;
  logic         status_wr_reg;
  logic [2:0]   port_power_reg;
  logic [2:0]   device_fixed_mask_reg;
  int           bad_count              = 0;
  int           n_checks               = 0;
  int           cycles                 = 0;
  int           seed                   = 11195;
  int           i;
  int           p;
  logic [2:0]   ppm;
  logic [2:0]   dfm;
  logic [2:0]   pwr;
  logic [31:0]  w;
  logic [31:0]  r;
  logic [31:0]  sw;

  rhpm_root_hub #(.PPM_RESET(3'h7), .DFM_RESET(3'h5)) u_rhpm_root_hub (
    .core_clk              (core_clk),
    .sys_rst               (sys_rst),
    .cmd_valid             (cmd_valid),
    .cmd_code              (cmd_code),
    .cmd_wdata             (cmd_wdata),
    .per_port_switch_select(per_port_switch_select),
    .global_op             (global_op),
    .port_op_on            (port_op_on),
    .port_op_off           (port_op_off),
    .hub_status_in         (hub_status_in),
    .hub_change_in         (hub_change_in),
    .rd_data_reg           (rd_data_reg),
    .rd_valid_reg          (rd_valid_reg),
    .port_power_reg        (port_power_reg),
    .device_fixed_mask_reg (device_fixed_mask_reg),
    .status_wr_data_reg    (status_wr_data_reg),
    .status_wr_reg         (status_wr_reg)
  );

  always #5 core_clk = ~core_clk;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // Cycle ceiling
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic fail(input string m);
    bad_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) fail($sformatf("word %h exp %h", g, e));
  endtask : chk32

  task automatic chk3(input logic [2:0] g, input logic [2:0] e);
    n_checks++;
    if (g !== e) fail($sformatf("mask %b exp %b", g, e));
  endtask : chk3

  task automatic chk1(input logic g, input logic e);
    n_checks++;
    if (g !== e) fail($sformatf("flag %b exp %b", g, e));
  endtask : chk1

  task automatic cmd(input logic [7:0] c, input logic [31:0] d, input logic rd, input logic wr);
    cmd_valid = 1'b1;
    cmd_code  = c;
    cmd_wdata = d;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    chk1(rd_valid_reg, rd);
    chk1(status_wr_reg, wr);
    @(negedge core_clk);
  endtask : cmd

  initial
  begin
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    ppm = 3'h6;
    dfm = 3'h4;
    pwr = 3'h0;
    cmd(`RHPM_CMD_MASKS_RD, 32'h0, 1'b1, 1'b0);
    chk32(rd_data_reg, {13'h0, ppm, 13'h0, dfm});
    chk3(port_power_reg, pwr);
    for (i = 0; i < 40; i++)
    begin
      w = $random(seed);
      r = $random(seed);
      cmd(`RHPM_CMD_MASKS_WR, w, 1'b0, 1'b0);
      ppm = {w[18:17], 1'b0};
      dfm = {w[2:1], 1'b0};
      cmd(`RHPM_CMD_MASKS_RD, r, 1'b1, 1'b0);
      chk32(rd_data_reg, {13'h0, ppm, 13'h0, dfm});
      chk3(device_fixed_mask_reg, dfm);
      per_port_switch_select = r[0];
      global_op   = rhpm_pwr_op_t'(r[2:1] % 2'd3);
      port_op_on  = r[6:4];
      port_op_off = r[9:7];
      for (p = 1; p < 3; p++)
        if (r[0] && ppm[p])
          pwr[p] = port_op_on[p] ? 1'b1 : (port_op_off[p] ? 1'b0 : pwr[p]);
        else if (global_op != RHPM_PWR_NONE)
          pwr[p] = (global_op == RHPM_PWR_ON);
      @(negedge core_clk);
      global_op   = RHPM_PWR_NONE;
      port_op_on  = 3'h0;
      port_op_off = 3'h0;
      repeat (2) @(negedge core_clk);
      chk3(port_power_reg, pwr);
      hub_status_in = r[31:16];
      hub_change_in = w[31:16];
      cmd(`RHPM_CMD_STATUS_RD, 32'h0, 1'b1, 1'b0);
      chk32(rd_data_reg, {w[31:16], r[31:16]});
      sw = w & 32'h8003FFFF;
      cmd(`RHPM_CMD_STATUS_WR, sw, 1'b0, 1'b1);
      chk32(status_wr_data_reg, sw);
      cmd(8'h15, r, 1'b0, 1'b0);
      chk32(rd_data_reg, {w[31:16], r[31:16]});
    end
    give_verdict();
  end
endmodule : testbench
